//--- verilog/sra_map.vh
// Constants of the serial register access port: addresses, field positions, counts
`ifndef SRA_MAP_VH
`define SRA_MAP_VH

// Word and frame geometry
`define SRA_WORD_W 16
`define SRA_CNT_W 5
`define SRA_ADDR_LAST 5'h0f
`define SRA_FRAME_LAST 5'h1f
`define SRA_CNT_RST 5'h00
`define SRA_CNT_ONE 5'h01

// Address word fields
`define SRA_DIR_BIT 15
`define SRA_IDX_W 15

// Register indices (address word bits 14..0)
`define SRA_IDX_MEAS 15'h0100
`define SRA_IDX_CHKSUM 15'h0108
`define SRA_IDX_LINPOS 15'h0122
`define SRA_IDX_SEQ 15'h000b

// Writable configuration block at indices 0 .. SRA_CFG_WORDS-1
`define SRA_CFG_WORDS 16
`define SRA_CFG_AW 4
`define SRA_CFG_HI_W 11
`define SRA_CFG_HI_ZERO 11'h000

// Sequencer control fields
`define SRA_READY_TRISTATE_ENABLE_BIT 1

// Reset values
`define SRA_WORD_RST 16'h0000
`define SRA_SYNC_W 3
// Synchroniser reset levels: chip select starts deselected, SCK and MOSI low
`define SRA_SYNC_RST 3'h4

// Configuration slot of the sequencer control word
`define SRA_SEQ_SLOT 4'hb
`define SRA_CFG_ONE 16'h0001

// Edge detector arming after reset
`define SRA_ARM_W 3
`define SRA_ARM_RST 3'h0

`endif

//--- verilog/sra_sync.v
// Two-flop synchroniser for a group of asynchronous inputs
module sra_sync
#(
    parameter WIDTH = 3,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
)
(
    // Clock and reset
    input wire i_sys_clk,
    input wire i_rstn,
    // Asynchronous inputs and their synchronised copies
    input wire [WIDTH-1:0] i_async,
    output wire [WIDTH-1:0] o_sync
);

    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1)
        begin : g_bit
            reg meta_ff;
            reg sync_ff;
            always @(posedge i_sys_clk or negedge i_rstn)
            begin
                if (!i_rstn)
                begin
                    meta_ff <= RST_VAL[g];
                    sync_ff <= RST_VAL[g];
                end
                else
                begin
                    meta_ff <= i_async[g];
                    sync_ff <= meta_ff;
                end
            end
            assign o_sync[g] = sync_ff;
        end
    endgenerate

endmodule

//--- verilog/sra_spi_slave.v
// Serial register access port: 32-bit SPI frames, register file, checksum and ready output
`include "sra_map.vh"

// What this block does
// - MOSI is captured and MISO is presented for capture on the rising SCK edge.
// - A frame is 32 bits: 16-bit address followed by 16 data bits.
// - Address bit 15 picks direction: zero reads, one writes configuration data.
// - Read frame shifts the addressed register out after the 16 address clocks.
// - Measurement reads return the latest finished result, updated once each completes.
// - Write frame shifts old contents out meanwhile; its 16 data bits are stored only at configuration indices.
// - During the next address after a write, MISO echoes the previous address word.
// - Ready rises on new measurement data, clears on reading measurement_result or linearized_position.
// - Each register read XORs the value read into the running checksum.
// - The running checksum is readable at register read_checksum.
// - Without chip select, frames are delimited by counting SCK cycles alone.
// - MISO is driven only while chip select is asserted, else released.
// - Every serially reachable register is 16 bits wide.
// - With ready tristate set, ready floats except driven high while selected with new measurement data pending.
module sra_spi_slave
(
    // Clock and reset
    input wire i_sys_clk,
    input wire i_rstn,
    // Serial pins
    input wire i_sck,
    input wire i_mosi,
    input wire i_cs_n,
    output wire o_miso,
    output wire o_miso_oe,
    // Measurement pipeline side
    input wire i_meas_valid,
    input wire [15:0] i_meas_result,
    input wire [15:0] i_lin_pos,
    // Ready pin
    output wire o_ready,
    output wire o_ready_oe,
    // Configuration towards the sequencer
    output wire [15:0] o_seq_ctrl
);

    wire [`SRA_SYNC_W-1:0] sync_out;
    wire sck_s;
    wire mosi_s;
    wire cs_n_s;

    // Chip select resets deselected, so MISO stays released right after reset
    sra_sync #(.WIDTH(`SRA_SYNC_W), .RST_VAL(`SRA_SYNC_RST)) u_sync
    (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_async({i_cs_n, i_mosi, i_sck}),
        .o_sync(sync_out)
    );

    assign sck_s = sync_out[0];
    assign mosi_s = sync_out[1];
    assign cs_n_s = sync_out[2];

    reg sck_d_ff;
    reg [`SRA_ARM_W-1:0] arm_ff;
    reg [`SRA_CNT_W-1:0] cnt_ff;
    reg [`SRA_WORD_W-1:0] rx_ff;
    reg [`SRA_WORD_W-1:0] addr_ff;
    reg [`SRA_WORD_W-1:0] tx_ff;
    reg [`SRA_WORD_W-1:0] rd_val_ff;
    reg [`SRA_WORD_W-1:0] chk_ff;
    reg [`SRA_WORD_W-1:0] meas_ff;
    reg [`SRA_WORD_W-1:0] lin_ff;
    reg rdy_flag_ff;
    reg ready_ff;
    reg ready_oe_ff;
    reg miso_oe_ff;

    reg [`SRA_CNT_W-1:0] nxt_cnt;
    reg [`SRA_WORD_W-1:0] nxt_tx;
    reg [`SRA_WORD_W-1:0] sel_val;

    wire sck_rise;
    wire [`SRA_WORD_W-1:0] rx_word;
    wire addr_done;
    wire frame_done;
    wire is_write;
    wire [`SRA_IDX_W-1:0] cur_idx;
    wire [`SRA_IDX_W-1:0] frm_idx;
    wire cfg_hit;
    wire [`SRA_CFG_WORDS-1:0] cfg_sel;
    wire rd_event;
    wire rdy_clear;
    wire [`SRA_WORD_W-1:0] cfg_rd [0:`SRA_CFG_WORDS-1];

    // Rising SCK seen after synchronisation; ignored until the detector holds a real pin level
    assign sck_rise = sck_s & ~sck_d_ff & arm_ff[`SRA_ARM_W-1];
    assign rx_word = {rx_ff[`SRA_WORD_W-2:0], mosi_s};
    assign addr_done = sck_rise & (cnt_ff == `SRA_ADDR_LAST);
    assign frame_done = sck_rise & (cnt_ff == `SRA_FRAME_LAST);
    assign cur_idx = rx_word[`SRA_IDX_W-1:0];
    assign frm_idx = addr_ff[`SRA_IDX_W-1:0];
    assign is_write = addr_ff[`SRA_DIR_BIT];
    assign cfg_hit = (frm_idx[`SRA_IDX_W-1:`SRA_CFG_AW] == `SRA_CFG_HI_ZERO);
    assign cfg_sel = `SRA_CFG_ONE << frm_idx[`SRA_CFG_AW-1:0];
    assign rd_event = addr_done & ~rx_word[`SRA_DIR_BIT];
    assign rdy_clear = rd_event & ((cur_idx == `SRA_IDX_MEAS) | (cur_idx == `SRA_IDX_LINPOS));

    // Register read mux on the address just completed
    always @*
    begin
        sel_val = `SRA_WORD_RST;
        case (cur_idx)
            `SRA_IDX_MEAS: sel_val = meas_ff;
            `SRA_IDX_CHKSUM: sel_val = chk_ff;
            `SRA_IDX_LINPOS: sel_val = lin_ff;
            default:
            begin
                if (cur_idx[`SRA_IDX_W-1:`SRA_CFG_AW] == `SRA_CFG_HI_ZERO)
                begin
                    sel_val = cfg_rd[cur_idx[`SRA_CFG_AW-1:0]];
                end
            end
        endcase
    end

    // Bit counter: cleared by chip select, otherwise free counting of SCK
    always @*
    begin
        nxt_cnt = cnt_ff;
        if (cs_n_s)
        begin
            nxt_cnt = `SRA_CNT_RST;
        end
        else if (sck_rise)
        begin
            nxt_cnt = cnt_ff + `SRA_CNT_ONE;
        end
    end

    // Transmit shifter: load at word boundaries, shift on all other rising edges while selected
    always @*
    begin
        nxt_tx = tx_ff;
        if (addr_done)
        begin
            nxt_tx = sel_val;
        end
        else if (frame_done)
        begin
            if (is_write)
            begin
                nxt_tx = addr_ff;
            end
            else
            begin
                nxt_tx = rd_val_ff;
            end
        end
        else if (sck_rise & ~cs_n_s)
        begin
            nxt_tx = {tx_ff[`SRA_WORD_W-2:0], 1'b0};
        end
    end

    always @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            sck_d_ff <= 1'b0;
            arm_ff <= `SRA_ARM_RST;
            cnt_ff <= `SRA_CNT_RST;
            rx_ff <= `SRA_WORD_RST;
            addr_ff <= `SRA_WORD_RST;
            tx_ff <= `SRA_WORD_RST;
            rd_val_ff <= `SRA_WORD_RST;
        end
        else
        begin
            sck_d_ff <= sck_s;
            arm_ff <= {arm_ff[`SRA_ARM_W-2:0], 1'b1};
            cnt_ff <= nxt_cnt;
            tx_ff <= nxt_tx;
            if (sck_rise & ~cs_n_s)
            begin
                rx_ff <= rx_word;
            end
            if (addr_done)
            begin
                addr_ff <= rx_word;
                rd_val_ff <= sel_val;
            end
        end
    end

    // Latest measurement results and the ready flag
    always @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            meas_ff <= `SRA_WORD_RST;
            lin_ff <= `SRA_WORD_RST;
            rdy_flag_ff <= 1'b0;
        end
        else
        begin
            if (i_meas_valid)
            begin
                meas_ff <= i_meas_result;
                lin_ff <= i_lin_pos;
                rdy_flag_ff <= 1'b1;
            end
            else if (rdy_clear)
            begin
                rdy_flag_ff <= 1'b0;
            end
        end
    end

    // Running checksum over every read value
    always @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            chk_ff <= `SRA_WORD_RST;
        end
        else if (rd_event)
        begin
            chk_ff <= chk_ff ^ sel_val;
        end
    end

    // Configuration words, written at the end of a write frame
    genvar g;
    generate
        for (g = 0; g < `SRA_CFG_WORDS; g = g + 1)
        begin : g_cfg
            reg [`SRA_WORD_W-1:0] word_ff;
            always @(posedge i_sys_clk or negedge i_rstn)
            begin
                if (!i_rstn)
                begin
                    word_ff <= `SRA_WORD_RST;
                end
                else if (frame_done & is_write & cfg_hit & cfg_sel[g])
                begin
                    word_ff <= rx_word;
                end
            end
            assign cfg_rd[g] = word_ff;
        end
    endgenerate

    // Pin drivers
    always @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            miso_oe_ff <= 1'b0;
            ready_ff <= 1'b0;
            ready_oe_ff <= 1'b0;
        end
        else
        begin
            miso_oe_ff <= ~cs_n_s;
            if (cfg_rd[`SRA_SEQ_SLOT][`SRA_READY_TRISTATE_ENABLE_BIT])
            begin
                ready_ff <= 1'b1;
                ready_oe_ff <= rdy_flag_ff & ~cs_n_s;
            end
            else
            begin
                ready_ff <= rdy_flag_ff;
                ready_oe_ff <= 1'b1;
            end
        end
    end

    assign o_miso = tx_ff[`SRA_WORD_W-1];
    assign o_miso_oe = miso_oe_ff;
    assign o_ready = ready_ff;
    assign o_ready_oe = ready_oe_ff;
    assign o_seq_ctrl = cfg_rd[`SRA_SEQ_SLOT];

endmodule

//--- tb/sra_spi_slave_asserts.sv
// Pin-level checks for the serial register access port
module sra_spi_slave_asserts
(
    // Watched pins
    input wire i_sys_clk,
    input wire i_rstn,
    input wire i_sck,
    input wire i_cs_n,
    input wire i_meas_valid,
    input wire o_miso,
    input wire o_miso_oe,
    input wire o_ready,
    input wire o_ready_oe,
    input wire [15:0] o_seq_ctrl
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rstn);
    property p_oe_on;
        $fell(i_cs_n) |-> ##[1:4] o_miso_oe;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("miso not enabled");
    property p_oe_off;
        i_cs_n [*5] |-> !o_miso_oe;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("miso not released");
    property p_miso_hold;
        (!i_cs_n && $stable(i_sck)) [*6] |-> $stable(o_miso);
    endproperty
    a_miso_hold: assert property (p_miso_hold) else $error("miso moved without sck");
    property p_rdy_set;
        i_meas_valid |-> ##2 o_ready;
    endproperty
    a_rdy_set: assert property (p_rdy_set) else $error("ready not raised");
    property p_rdy_tri;
        $past(o_seq_ctrl[1]) && o_seq_ctrl[1] |-> o_ready;
    endproperty
    a_rdy_tri: assert property (p_rdy_tri) else $error("ready level low in tristate");
    property p_rdy_tri_oe;
        (o_seq_ctrl[1] && i_cs_n) [*5] |-> !o_ready_oe;
    endproperty
    a_rdy_tri_oe: assert property (p_rdy_tri_oe) else $error("ready driven unselected");
    property p_rdy_on;
        !o_seq_ctrl[1] [*3] |-> o_ready_oe;
    endproperty
    a_rdy_on: assert property (p_rdy_on) else $error("ready not driven");
    property p_cfg_hold;
        i_cs_n [*6] |-> $stable(o_seq_ctrl);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("config changed unselected");
    c_tri: cover property (o_seq_ctrl[1] && o_ready_oe);
    c_clr: cover property ($fell(o_ready));
    c_sel: cover property ($rose(o_miso_oe));
endmodule

//--- tb/sra_spi_master.sv
// Behavioural SPI master driving 32-bit frames
module sra_spi_master
(
    // Clock and returned data
    input wire i_sys_clk,
    input wire i_miso,
    input wire i_miso_oe,
    // Serial outputs
    output logic o_sck,
    output logic o_mosi,
    output logic o_cs_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // Released line shows no stale value
    wire miso_w = i_miso_oe ? i_miso : ~i_miso;
    initial
    begin
        o_sck = 1'b0;
        o_mosi = 1'b0;
        o_cs_n = 1'b1;
    end
    task automatic frame(input logic [31:0] w, output logic [31:0] r);
        for (int i = 31; i >= 0; i--)
        begin
            @(posedge i_sys_clk);
            o_cs_n <= 1'b0;
            o_sck <= 1'b0;
            o_mosi <= w[i];
            repeat (4) @(posedge i_sys_clk);
            o_sck <= 1'b1;
            r[i] = miso_w;
            repeat (3) @(posedge i_sys_clk);
        end
    endtask
    task automatic idle();
        @(posedge i_sys_clk);
        o_sck <= 1'b0;
        o_cs_n <= 1'b1;
        repeat (7) @(posedge i_sys_clk);
    endtask
endmodule

//--- tb/testbench.sv
// Self-checking bench for the serial register access port
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_sys_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic i_meas_valid = 1'b0;
    logic [15:0] i_meas_result = 16'h0000;
    logic [15:0] i_lin_pos = 16'h0000;
    wire i_sck, i_mosi, i_cs_n, o_miso, o_miso_oe, o_ready, o_ready_oe;
    wire [15:0] o_seq_ctrl;
    int n_errors = 0;
    int comparisons = 0;
    logic [31:0] r;
    always #5 i_sys_clk = ~i_sys_clk;
    sra_spi_slave u_sra_spi_slave (.i_sys_clk, .i_rstn, .i_sck, .i_mosi, .i_cs_n, .o_miso, .o_miso_oe,
        .i_meas_valid, .i_meas_result, .i_lin_pos, .o_ready, .o_ready_oe, .o_seq_ctrl);
    sra_spi_master u_sra_spi_master (.i_sys_clk, .i_miso(o_miso), .i_miso_oe(o_miso_oe), .o_sck(i_sck),
        .o_mosi(i_mosi), .o_cs_n(i_cs_n));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_sim();
        if (n_errors == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // One frame; upper half is the echo, lower half the register data
    task automatic xfer(input logic [15:0] a, input logic [15:0] d, input logic [31:0] exp);
        u_sra_spi_master.frame({a, d}, r);
        check("frame", r, exp);
    endtask
    task automatic meas(input logic [15:0] m, input logic [15:0] l);
        @(posedge i_sys_clk);
        i_meas_valid <= 1'b1;
        i_meas_result <= m;
        i_lin_pos <= l;
        @(posedge i_sys_clk);
        i_meas_valid <= 1'b0;
        repeat (3) @(posedge i_sys_clk);
    endtask
    initial
    begin
        #200000;
        n_errors++;
        end_sim();
    end
    initial
    begin
        repeat (10) @(posedge i_sys_clk);
        i_rstn <= 1'b1;
        repeat (4) @(posedge i_sys_clk);
        check("ready", {o_ready, o_ready_oe}, 2'h1);
        xfer(16'h0108, 16'h0000, 32'h0000_0000);
        meas(16'h1234, 16'h5a5a);
        check("ready", {o_ready, o_ready_oe}, 2'h3);
        xfer(16'h0100, 16'h0000, 32'h0000_1234);
        check("ready", {o_ready, o_ready_oe}, 2'h1);
        meas(16'hbeef, 16'h0f0f);
        xfer(16'h0122, 16'h0000, 32'h1234_0f0f);
        xfer(16'h0108, 16'h0000, 32'h0f0f_1d3b);
        xfer(16'h800b, 16'h0002, 32'h1d3b_0000);
        xfer(16'h000b, 16'h0000, 32'h800b_0002);
        check("seq", o_seq_ctrl, 16'h0002);
        check("ready", {o_ready, o_ready_oe}, 2'h2);
        meas(16'h0001, 16'h0002);
        check("ready", {o_ready, o_ready_oe}, 2'h3);
        u_sra_spi_master.idle();
        check("pins", {o_ready, o_ready_oe, o_miso_oe}, 3'h4);
        xfer(16'h8100, 16'hffff, 32'h0002_0001);
        xfer(16'h0100, 16'h0000, 32'h8100_0001);
        check("ready", {o_ready, o_ready_oe}, 2'h2);
        xfer(16'h800b, 16'h0000, 32'h0001_0002);
        u_sra_spi_master.idle();
        check("pins", {o_ready, o_ready_oe, o_miso_oe}, 3'h2);
        // Second reset in mid-run with a pending result and a nonzero checksum
        meas(16'h4321, 16'h8765);
        check("ready", {o_ready, o_ready_oe}, 2'h3);
        @(posedge i_sys_clk);
        i_rstn <= 1'b0;
        repeat (3) @(posedge i_sys_clk);
        i_rstn <= 1'b1;
        repeat (4) @(posedge i_sys_clk);
        check("pins", {o_ready, o_ready_oe, o_miso_oe}, 3'h2);
        xfer(16'h0108, 16'h0000, 32'h0000_0000);
        xfer(16'h0100, 16'h0000, 32'h0000_0000);
        end_sim();
    end
endmodule
bind sra_spi_slave sra_spi_slave_asserts u_sra_spi_slave_asserts (.i_sys_clk, .i_rstn, .i_sck, .i_cs_n,
    .i_meas_valid, .o_miso, .o_miso_oe, .o_ready, .o_ready_oe, .o_seq_ctrl);
